//--- rtl/dpx_pkg.sv
package dpx_pkg;
   // bus and component widths
   localparam int BUS_W    = 12;
   localparam int COMP_W   = 8;
   localparam int FMT_W    = 3;
   localparam int CFG_W    = FMT_W + 2;
   // input format codes
   localparam logic [FMT_W-1:0] FMT_RGB24  = 3'h0;
   localparam logic [FMT_W-1:0] FMT_RGB15  = 3'h1;
   localparam logic [FMT_W-1:0] FMT_RGB16  = 3'h2;
   localparam logic [FMT_W-1:0] FMT_YCC422 = 3'h3;
   // format 0 field bounds
   localparam int F0_R_MSB   = 11;
   localparam int F0_R_LSB   = 4;
   localparam int F0_GHI_MSB = 3;
   localparam int F0_GLO_MSB = 11;
   localparam int F0_GLO_LSB = 8;
   // low byte of a half-word
   localparam int BYTE_MSB   = 7;
   // formats 1 and 2 field bounds
   localparam int F15_R_MSB  = 6;
   localparam int F15_R_LSB  = 2;
   localparam int F15_GHI_MSB = 1;
   localparam int F16_R_MSB  = 7;
   localparam int F16_R_LSB  = 3;
   localparam int F16_GHI_MSB = 2;
   localparam int FG_LO_MSB  = 7;
   localparam int FG_LO_LSB  = 5;
   localparam int FB_MSB     = 4;
   // capture sequencer states
   typedef enum logic {WAIT_FIRST, WAIT_SECOND} dpx_state_type;
endpackage

//--- rtl/dpx_cap_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dpx_cap_if;
   import dpx_pkg::*;
   logic                 rise;
   logic                 fall;
   logic [BUS_W-1:0]     word;
   logic [FMT_W-1:0]     fmt;
   logic                 edgeOrder;
   logic                 slotOrder;
   modport src (output rise, output fall, output word, output fmt, output edgeOrder, output slotOrder);
   modport snk (input rise, input fall, input word, input fmt, input edgeOrder, input slotOrder);
endinterface
`default_nettype wire

//--- rtl/dpx_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dpx_edge_sync
   import dpx_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              pixClk,
   input  wire logic [BUS_W-1:0]  pixBus,
   input  wire logic [FMT_W-1:0]  pixFormat,
   input  wire logic              edgeOrder,
   input  wire logic              slotOrder,
   dpx_cap_if.src                 cap
);
   localparam int VEC_W = BUS_W + CFG_W + 1;

   logic [VEC_W-1:0] meta_reg;
   logic [VEC_W-1:0] meta_next;
   logic [VEC_W-1:0] sync_reg;
   logic [VEC_W-1:0] sync_next;
   logic             clkLast_reg;
   logic             clkLast_next;

   // two-stage synchroniser, clock edges found after it
   always_comb begin
      meta_next    = {pixClk, pixFormat, edgeOrder, slotOrder, pixBus};
      sync_next    = meta_reg;
      clkLast_next = sync_reg[VEC_W-1];
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg    <= '0;
         sync_reg    <= '0;
         clkLast_reg <= 1'b0;
      end else begin
         meta_reg    <= meta_next;
         sync_reg    <= sync_next;
         clkLast_reg <= clkLast_next;
      end
   end

   assign cap.rise      = sync_reg[VEC_W-1] & ~clkLast_reg;
   assign cap.fall      = ~sync_reg[VEC_W-1] & clkLast_reg;
   assign cap.word      = sync_reg[BUS_W-1:0];
   assign cap.slotOrder = sync_reg[BUS_W];
   assign cap.edgeOrder = sync_reg[BUS_W+1];
   assign cap.fmt       = sync_reg[VEC_W-2:BUS_W+2];

   edges_exclusive_a: assert property (@(posedge clk) disable iff (!rstn) !(cap.rise && cap.fall))
      else $error("rise and fall strobes together");
endmodule
`default_nettype wire

//--- rtl/dpx_top.sv
// Summary of operation
// - edge bit 0: first half on rising edge; bit 1: first half on falling edge.
// - slot bit 0: green-3 half is first data; slot bit 1 swaps the halves.
// - format 0 green-3 half: green 3..0 on bits 11..8, blue on 7..0.
// - format 0 red half: red on bits 11..4, green 7..4 on bits 3..0.
// - format 1: 5-5-5 RGB on low byte, bit 7 of red half ignored.
// - format 2: 5-6-5 RGB on low byte of both halves.
// - format 3: Cb, Y0 in cycle n; Cr, Y1 in cycle n+1.
`timescale 1ns/10ps
`default_nettype none
module dpx_top
   import dpx_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              pixClk,
   input  wire logic [BUS_W-1:0]  pixBus,
   input  wire logic [FMT_W-1:0]  pixFormat,
   input  wire logic              edgeOrder,
   input  wire logic              slotOrder,
   output logic                   pixValid,
   output logic [COMP_W-1:0]      pixRed,
   output logic [COMP_W-1:0]      pixGreen,
   output logic [COMP_W-1:0]      pixBlue,
   output logic [COMP_W-1:0]      pixLuma1
);
   dpx_cap_if cap ();

   dpx_edge_sync u_sync (
      .clk       (clk),
      .rstn      (rstn),
      .pixClk    (pixClk),
      .pixBus    (pixBus),
      .pixFormat (pixFormat),
      .edgeOrder (edgeOrder),
      .slotOrder (slotOrder),
      .cap       (cap)
   );

   dpx_state_type     state_reg;
   dpx_state_type     state_next;
   logic [BUS_W-1:0]  firstHalf_reg;
   logic [BUS_W-1:0]  firstHalf_next;
   logic [CFG_W-1:0]  cfg_reg;
   logic [CFG_W-1:0]  cfg_next;
   logic              phase_reg;
   logic              phase_next;
   logic [COMP_W-1:0] cbHold_reg;
   logic [COMP_W-1:0] cbHold_next;
   logic [COMP_W-1:0] y0Hold_reg;
   logic [COMP_W-1:0] y0Hold_next;
   logic              valid_reg;
   logic              valid_next;
   logic [COMP_W-1:0] red_reg;
   logic [COMP_W-1:0] red_next;
   logic [COMP_W-1:0] green_reg;
   logic [COMP_W-1:0] green_next;
   logic [COMP_W-1:0] blue_reg;
   logic [COMP_W-1:0] blue_next;
   logic [COMP_W-1:0] luma1_reg;
   logic [COMP_W-1:0] luma1_next;
   logic              firstEdge;
   logic              secondEdge;
   logic [BUS_W-1:0]  gHalf;
   logic [BUS_W-1:0]  rHalf;
   logic [CFG_W-1:0]  cfgNow;

   assign firstEdge  = cap.edgeOrder ? cap.fall : cap.rise;
   assign secondEdge = cap.edgeOrder ? cap.rise : cap.fall;
   assign gHalf  = cap.slotOrder ? cap.word : firstHalf_reg;
   assign rHalf  = cap.slotOrder ? firstHalf_reg : cap.word;
   assign cfgNow = {cap.fmt, cap.edgeOrder, cap.slotOrder};

   always_comb begin
      state_next     = state_reg;
      firstHalf_next = firstHalf_reg;
      cfg_next       = cfgNow;
      phase_next     = phase_reg;
      cbHold_next    = cbHold_reg;
      y0Hold_next    = y0Hold_reg;
      valid_next     = 1'b0;
      red_next       = red_reg;
      green_next     = green_reg;
      blue_next      = blue_reg;
      luma1_next     = luma1_reg;
      if (cfgNow != cfg_reg) begin
         // restart alignment on any mode change
         state_next = WAIT_FIRST;
         phase_next = 1'b0;
      end else begin
         case (state_reg)
            WAIT_FIRST: begin
               if (firstEdge) begin
                  firstHalf_next = cap.word;
                  state_next     = WAIT_SECOND;
               end
            end
            WAIT_SECOND: begin
               if (secondEdge) begin
                  state_next = WAIT_FIRST;
                  case (cap.fmt)
                     FMT_RGB24: begin
                        valid_next = 1'b1;
                        red_next   = rHalf[F0_R_MSB:F0_R_LSB];
                        green_next = {rHalf[F0_GHI_MSB:0], gHalf[F0_GLO_MSB:F0_GLO_LSB]};
                        blue_next  = gHalf[BYTE_MSB:0];
                        luma1_next = '0;
                     end
                     FMT_RGB15: begin
                        valid_next = 1'b1;
                        red_next   = {3'h0, rHalf[F15_R_MSB:F15_R_LSB]};
                        green_next = {3'h0, rHalf[F15_GHI_MSB:0], gHalf[FG_LO_MSB:FG_LO_LSB]};
                        blue_next  = {3'h0, gHalf[FB_MSB:0]};
                        luma1_next = '0;
                     end
                     FMT_RGB16: begin
                        valid_next = 1'b1;
                        red_next   = {3'h0, rHalf[F16_R_MSB:F16_R_LSB]};
                        green_next = {2'h0, rHalf[F16_GHI_MSB:0], gHalf[FG_LO_MSB:FG_LO_LSB]};
                        blue_next  = {3'h0, gHalf[FB_MSB:0]};
                        luma1_next = '0;
                     end
                     FMT_YCC422: begin
                        if (!phase_reg) begin
                           cbHold_next = gHalf[BYTE_MSB:0];
                           y0Hold_next = rHalf[BYTE_MSB:0];
                           phase_next  = 1'b1;
                        end else begin
                           valid_next  = 1'b1;
                           blue_next   = cbHold_reg;
                           green_next  = y0Hold_reg;
                           red_next    = gHalf[BYTE_MSB:0];
                           luma1_next  = rHalf[BYTE_MSB:0];
                           phase_next  = 1'b0;
                        end
                     end
                     default: begin
                        valid_next = 1'b0;
                     end
                  endcase
               end
            end
            default: begin
               state_next = WAIT_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg     <= WAIT_FIRST;
         firstHalf_reg <= '0;
         cfg_reg       <= '0;
         phase_reg     <= 1'b0;
         cbHold_reg    <= '0;
         y0Hold_reg    <= '0;
         valid_reg     <= 1'b0;
         red_reg       <= '0;
         green_reg     <= '0;
         blue_reg      <= '0;
         luma1_reg     <= '0;
      end else begin
         state_reg     <= state_next;
         firstHalf_reg <= firstHalf_next;
         cfg_reg       <= cfg_next;
         phase_reg     <= phase_next;
         cbHold_reg    <= cbHold_next;
         y0Hold_reg    <= y0Hold_next;
         valid_reg     <= valid_next;
         red_reg       <= red_next;
         green_reg     <= green_next;
         blue_reg      <= blue_next;
         luma1_reg     <= luma1_next;
      end
   end

   assign pixValid = valid_reg;
   assign pixRed   = red_reg;
   assign pixGreen = green_reg;
   assign pixBlue  = blue_reg;
   assign pixLuma1 = luma1_reg;

   // helper slices for checks
   logic [COMP_W-1:0] wordLow;
   logic [COMP_W-1:0] firstHi;
   assign wordLow = cap.word[BYTE_MSB:0];
   assign firstHi = firstHalf_reg[F0_R_MSB:F0_R_LSB];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   first_capture_a: assert property (
      state_reg == WAIT_FIRST && firstEdge && cfgNow == cfg_reg
      |=> state_reg == WAIT_SECOND && firstHalf_reg == $past(cap.word))
      else $error("first half not captured on first edge");
   first_no_valid_a: assert property (
      firstEdge |=> !valid_reg)
      else $error("output after first edge only");
   slot_blue_a: assert property (
      state_reg == WAIT_SECOND && secondEdge && cap.slotOrder && cap.fmt == FMT_RGB24
      && cfgNow == cfg_reg |=> valid_reg && blue_reg == $past(wordLow) && red_reg == $past(firstHi))
      else $error("slot swap not applied");
   fmt0_blue_a: assert property (
      state_reg == WAIT_SECOND && secondEdge && !cap.slotOrder && cap.fmt == FMT_RGB24
      && cfgNow == cfg_reg |=> valid_reg && blue_reg == $past(firstHalf_reg[BYTE_MSB:0]))
      else $error("format 0 blue wrong");
   fmt0_red_a: assert property (
      state_reg == WAIT_SECOND && secondEdge && !cap.slotOrder && cap.fmt == FMT_RGB24
      && cfgNow == cfg_reg |=> red_reg == $past(cap.word[F0_R_MSB:F0_R_LSB]))
      else $error("format 0 red wrong");
   fmt1_width_a: assert property (
      valid_reg && cfg_reg[CFG_W-1:2] == FMT_RGB15 |-> red_reg[7:5] == 3'h0 && green_reg[7:5] == 3'h0)
      else $error("format 1 field too wide");
   fmt2_width_a: assert property (
      valid_reg && cfg_reg[CFG_W-1:2] == FMT_RGB16 |-> green_reg[7:6] == 2'h0 && blue_reg[7:5] == 3'h0)
      else $error("format 2 field too wide");
   pair_phase_a: assert property (
      valid_reg && cfg_reg[CFG_W-1:2] == FMT_YCC422 |-> $past(phase_reg) && !phase_reg)
      else $error("pair output before second cycle");
   unused_fmt_a: assert property (
      cap.fmt > FMT_YCC422 ##1 cap.fmt > FMT_YCC422 |=> !valid_reg)
      else $error("output in unsupported format");

   fmt0_seen_c:  cover property (valid_reg && cfg_reg[CFG_W-1:2] == FMT_RGB24);
   fmt3_seen_c:  cover property (valid_reg && cfg_reg[CFG_W-1:2] == FMT_YCC422);
   edge1_seen_c: cover property (valid_reg && cfg_reg[1]);
   slot1_seen_c: cover property (valid_reg && cfg_reg[0]);
endmodule
`default_nettype wire

//--- testbench/dpx_gfx_model.sv
`timescale 1ns/10ps
`default_nettype none
module dpx_gfx_model
   import dpx_pkg::*;
(
   output logic              pixClk,
   output logic [BUS_W-1:0]  pixBus
);
   // clock stands still between frames
   initial begin
      pixClk = 1'b0;
      pixBus = '0;
   end
   // one half: set up, edge, hold
   task automatic put_half(input logic [BUS_W-1:0] w, input logic lvl);
      pixBus = w;
      #50;
      pixClk = lvl;
      #50;
   endtask
   task automatic send(input logic [BUS_W-1:0] h1, input logic [BUS_W-1:0] h2, input logic edgeBit, input int gap);
      pixClk = edgeBit;
      #(100 + gap);
      put_half(h1, ~edgeBit);
      put_half(h2, edgeBit);
      // released bus shows the inverse
      pixBus = ~h2;
   endtask
endmodule
`default_nettype wire

//--- testbench/dpx_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module dpx_top_test;
   import dpx_pkg::*;
   logic                 clk;
   logic                 rstn;
   logic [FMT_W-1:0]     pixFormat;
   logic                 edgeOrder;
   logic                 slotOrder;
   wire logic            pixClk;
   wire logic [BUS_W-1:0] pixBus;
   logic                 pixValid;
   logic [COMP_W-1:0]    pixRed;
   logic [COMP_W-1:0]    pixGreen;
   logic [COMP_W-1:0]    pixBlue;
   logic [COMP_W-1:0]    pixLuma1;
   logic [4*COMP_W-1:0]  got;
   int                   mismatches;
   int                   nTests;
   int                   nPulse;
   int                   n0;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   dpx_top i_dpx_top (.clk(clk), .rstn(rstn), .pixClk(pixClk), .pixBus(pixBus), .pixFormat(pixFormat),
      .edgeOrder(edgeOrder), .slotOrder(slotOrder), .pixValid(pixValid), .pixRed(pixRed),
      .pixGreen(pixGreen), .pixBlue(pixBlue), .pixLuma1(pixLuma1));
   dpx_gfx_model i_dpx_gfx_model (.pixClk(pixClk), .pixBus(pixBus));

   // pulse count and capture
   always @(posedge clk) begin
      if (pixValid === 1'b1) begin
         nPulse <= nPulse + 1;
         got <= {pixRed, pixGreen, pixBlue, pixLuma1};
      end
   end

   function automatic logic [2*BUS_W-1:0] halves(input logic [FMT_W-1:0] f, input logic [COMP_W-1:0] r,
      input logic [COMP_W-1:0] g, input logic [COMP_W-1:0] b, input logic [4:0] j);
      case (f)
         FMT_RGB24: halves = {r, g[7:4], g[3:0], b};
         FMT_RGB15: halves = {j[3:0], j[4], r[4:0], g[4:3], j[3:0], g[2:0], b[4:0]};
         FMT_RGB16: halves = {j[3:0], r[4:0], g[5:3], j[3:0], g[2:0], b[4:0]};
         default:   halves = {j[3:0], g, j[3:0], b};
      endcase
   endfunction

   function automatic logic [4*COMP_W-1:0] expect_pix(input logic [FMT_W-1:0] f, input logic [4*COMP_W-1:0] v);
      case (f)
         FMT_RGB24: expect_pix = {v[31:8], 8'h00};
         FMT_RGB15: expect_pix = {3'h0, v[28:24], 3'h0, v[20:16], 3'h0, v[12:8], 8'h00};
         FMT_RGB16: expect_pix = {3'h0, v[28:24], 2'h0, v[21:16], 3'h0, v[12:8], 8'h00};
         default:   expect_pix = v;
      endcase
   endfunction

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check_pix(input logic [4*COMP_W-1:0] exp);
      nTests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: pixel %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_count(input int exp);
      nTests++;
      if (nPulse != exp) begin
         mismatches++;
         $display("Error at %0t: %0d pulses expected %0d", $time, nPulse, exp);
      end
   endtask

   task automatic wait_pulse(input int exp);
      for (int i = 0; i < 20 && nPulse != exp; i++) begin
         @(posedge clk);
      end
      if (nPulse != exp) begin
         mismatches++;
         $display("Error at %0t: no pixel pulse in time", $time);
         tally_and_finish();
      end
   endtask

   task automatic set_cfg(input logic [FMT_W-1:0] f, input logic e, input logic s);
      @(posedge clk);
      #1;
      pixFormat = f;
      edgeOrder = e;
      slotOrder = s;
      repeat (8) @(posedge clk);
   endtask

   task automatic run_pixel(input logic [FMT_W-1:0] f, input logic e, input logic s);
      logic [4*COMP_W-1:0] v;
      logic [2*BUS_W-1:0]  hv;
      logic [4:0]          j;
      int                  base;
      v = $urandom;
      j = 5'($urandom);
      base = nPulse;
      hv = halves(f, v[31:24], v[23:16], v[15:8], j);
      i_dpx_gfx_model.send(s ? hv[23:12] : hv[11:0], s ? hv[11:0] : hv[23:12], e, $urandom_range(0, 300));
      if (f == FMT_YCC422) begin
         repeat (6) @(posedge clk);
         check_count(base);
         hv = halves(f, 8'h00, v[7:0], v[31:24], j);
         i_dpx_gfx_model.send(s ? hv[23:12] : hv[11:0], s ? hv[11:0] : hv[23:12], e, $urandom_range(0, 300));
      end
      wait_pulse(base + 1);
      check_pix(expect_pix(f, v));
      repeat (4) @(posedge clk);
      check_count(base + 1);
   endtask

   initial begin
      #2000000;
      mismatches++;
      $display("Error at %0t: run too long", $time);
      tally_and_finish();
   end

   initial begin
      rstn = 1'b0;
      pixFormat = FMT_RGB24;
      edgeOrder = 1'b0;
      slotOrder = 1'b0;
      mismatches = 0;
      nTests = 0;
      nPulse = 0;
      got = '0;
      void'($urandom(94));
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      // formats 0 to 3 with every edge and slot order
      for (int k = 0; k < 16; k++) begin
         set_cfg(3'(k / 4), k[1], k[0]);
         repeat (3) run_pixel(3'(k / 4), k[1], k[0]);
         $display("test format %0d edge %0d slot %0d done", k / 4, k[1], k[0]);
      end
      // random mix of configurations
      for (int k = 0; k < 20; k++) begin
         n0 = $urandom_range(0, 63);
         set_cfg(3'(n0 % 4), n0[4], n0[5]);
         run_pixel(3'(n0 % 4), n0[4], n0[5]);
      end
      $display("test random mix done");
      // half pixel, then config change aborts it
      set_cfg(FMT_RGB24, 1'b0, 1'b0);
      n0 = nPulse;
      i_dpx_gfx_model.put_half(12'h000, 1'b0);
      i_dpx_gfx_model.put_half(12'($urandom), 1'b1);
      set_cfg(FMT_RGB16, 1'b0, 1'b0);
      check_count(n0);
      run_pixel(FMT_RGB16, 1'b0, 1'b0);
      $display("test abort done");
      // formats without output
      for (int f = 4; f < 8; f++) begin
         set_cfg(3'(f), 1'b0, 1'b0);
         n0 = nPulse;
         i_dpx_gfx_model.send(12'h5A5, 12'hA5A, 1'b0, 0);
         repeat (10) @(posedge clk);
         check_count(n0);
      end
      $display("test unused formats done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
